// file: tbt_mem_if.sv
// Port between the table controller and the row storage.
interface tbt_mem_if;
    import tbt_pkg::*;

    logic      wr_en;                                // Write the addressed row.
    tbt_ptr_t  wr_addr;                              // Row to write.
    tbt_code_t wr_data;                              // Coded row contents.
    logic      rd_en;                                // Fetch the addressed row.
    tbt_ptr_t  rd_addr;                              // Row to fetch.
    tbt_code_t rd_data;                              // Registered row contents.

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_en, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data,
                  input rd_en, input rd_addr, output rd_data);
endinterface

// file: tbt_pkg.sv
package tbt_pkg;

    // ------------------------------------------------------------------
    // Table geometry and field widths
    // ------------------------------------------------------------------
    localparam int ROWS       = 32;                  // Rows in the trigger log table.
    localparam int PTR_W      = 5;                   // Row index and trigger identifier width.
    localparam int TAG_USER_W = 5;                   // User code carried by a trigger command.
    localparam int TAG_POS_W  = 2;                   // Position within the covered crossings.
    localparam int TAG_W      = TAG_USER_W + TAG_POS_W; // Stored tag width (7 bits).
    localparam int BCID_W     = 16;                  // Bunch-crossing counter width.
    localparam int LAT_W      = 9;                   // Programmed latency width.
    localparam int DATA_W     = TAG_W + BCID_W;      // Payload bits held in one row.
    localparam int PAR_W      = 5;                   // Hamming check bits for the payload.
    localparam int CODE_W     = DATA_W + PAR_W;      // Coded row width.

    // ------------------------------------------------------------------
    // Field positions inside the payload word
    // ------------------------------------------------------------------
    localparam int DATA_BCID_LSB = 0;                // Crossing identifier sits low.
    localparam int DATA_TAG_LSB  = BCID_W;           // Tag sits above it.

    // ------------------------------------------------------------------
    // Reset values and fixed codes
    // ------------------------------------------------------------------
    localparam logic [PTR_W-1:0]      PTR_RST      = 5'h00;    // Pointer clear value.
    localparam logic [BCID_W-1:0]     BCID_RST     = 16'h0000; // Counter clear value.
    localparam logic [BCID_W-1:0]     BCID_STEP    = 16'h0001; // Advance per crossing.
    localparam logic [PTR_W-1:0]      PTR_STEP     = 5'h01;    // Advance per row.
    localparam logic [TAG_USER_W-1:0] EXT_TAG_USER = 5'h00;    // Tag for pin-driven triggers.
    localparam logic [TAG_POS_W-1:0]  EXT_TAG_POS  = 2'h0;     // Position for pin triggers.

    typedef logic [PTR_W-1:0]  tbt_ptr_t;            // Row pointer.
    typedef logic [BCID_W-1:0] tbt_bcid_t;           // Crossing identifier.
    typedef logic [TAG_W-1:0]  tbt_tag_t;            // Stored trigger tag.
    typedef logic [DATA_W-1:0] tbt_data_t;           // Uncoded row payload.
    typedef logic [CODE_W-1:0] tbt_code_t;           // Hamming coded row.

    // Bitwise majority of three pointer copies.
    function automatic tbt_ptr_t tbt_vote_ptr(input tbt_ptr_t a, input tbt_ptr_t b,
                                              input tbt_ptr_t c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    // Bitwise majority of three counter copies.
    function automatic tbt_bcid_t tbt_vote_bcid(input tbt_bcid_t a, input tbt_bcid_t b,
                                                input tbt_bcid_t c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    // Hamming encoder: data at non power-of-two positions, checks at powers of two.
    function automatic tbt_code_t tbt_ham_enc(input tbt_data_t d);
        tbt_code_t         cw;
        int                k;
        logic [PAR_W-1:0]  syn;
        cw  = '0;
        k   = 0;
        syn = '0;
        for (int p = 1; p <= CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p-1] = d[k];
                k++;
            end
        end
        for (int p = 1; p <= CODE_W; p++) begin
            if (cw[p-1]) begin
                syn = syn ^ PAR_W'(p);
            end
        end
        for (int i = 0; i < PAR_W; i++) begin
            cw[(1 << i) - 1] = syn[i];
        end
        return cw;
    endfunction

    // Hamming decoder: the syndrome names the flipped position, which is put right.
    function automatic tbt_data_t tbt_ham_dec(input tbt_code_t c);
        tbt_code_t         cw;
        tbt_data_t         d;
        int                k;
        logic [PAR_W-1:0]  syn;
        cw  = c;
        d   = '0;
        k   = 0;
        syn = '0;
        for (int p = 1; p <= CODE_W; p++) begin
            if (cw[p-1]) begin
                syn = syn ^ PAR_W'(p);
            end
        end
        if (syn != '0 && int'(syn) <= CODE_W) begin
            cw[int'(syn) - 1] = ~cw[int'(syn) - 1];
        end
        for (int p = 1; p <= CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[k] = cw[p-1];
                k++;
            end
        end
        return d;
    endfunction

endpackage

// file: tbt_rd_model.sv
// Readout logic: takes offered rows at a random pace, or holds off while stalled.
module tbt_rd_model (
    input  wire logic sys_clk,          // Crossing clock.
    input  wire logic stall,            // Bench holds readout busy.
    output logic      rd_ready = 1'b0   // Accepts the offered row.
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge sys_clk) begin
        rd_ready <= !stall && ($urandom % 3 != 0);
    end
endmodule // tbt_rd_model

// file: tbt_row_mem.sv
// --------------------------------------------------------------------------
// Row storage for the trigger log table
// --------------------------------------------------------------------------
module tbt_row_mem import tbt_pkg::*; #(
    parameter int DEPTH = ROWS                       // Number of rows.
) (
    input  wire logic sys_clk,                       // Bunch-crossing clock.
    input  wire logic rst,                           // Asynchronous reset, active high.
    tbt_mem_if.mem    port                           // Storage side port.
);

    tbt_code_t store_q [DEPTH];                      // Row array, no reset on purpose.
    tbt_code_t rd_data_q;                            // Registered read word.

    // The array has no reset so it maps onto plain storage cells; occupancy
    // is tracked by the controller, so stale contents are never presented.
    always_ff @(posedge sys_clk) begin
        if (port.wr_en) begin
            store_q[port.wr_addr] <= port.wr_data;
        end
    end

    // Read data come from a register, one cycle after the fetch request.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= '0;
        end else if (port.rd_en) begin
            rd_data_q <= store_q[port.rd_addr];
        end
    end

    assign port.rd_data = rd_data_q;

endmodule // tbt_row_mem

// file: tbt_trigger_table.sv
// Notes on behaviour
// - At most one trigger per crossing.
// - Decoder or bypass pin triggers, same handling.
// - No self-trigger from hit activity.
// - Table holds thirty-two rows.
// - Triggers fill next free row, in order.
// - Forward each logged trigger pulse to matrix.
// - Send five-bit row index with pulse.
// - Row holds tag and crossing identifier.
// - Tag is user code plus position.
// - Crossing counter advances every clock.
// - Counter reset command clears crossing counter.
// - Readout drains rows first in first out.
// - Read row is cleared and freed.
// - Readout runs until table is empty.
// - Pointers and counter triple redundant, voted.
// - Rows Hamming coded, single flips corrected.
// - Event reset clears table and pointers.
// - Power-on reset is no event reset.
module tbt_trigger_table import tbt_pkg::*; (
    input  wire logic              sys_clk,                 // Bunch-crossing clock.
    input  wire logic              rst,                     // Power-on reset, active high.
    input  wire logic              cmd_trig_pulse,          // Trigger from command decoder.
    input  wire logic [TAG_USER_W-1:0] cmd_trig_tag,        // User code of that trigger.
    input  wire logic [TAG_POS_W-1:0]  cmd_trig_pos,        // Crossing position of it.
    input  wire logic              ext_trig_pin,            // Trigger pin used in bypass.
    input  wire logic              bypass_pin,              // Decoder bypass strap.
    input  wire logic              bunch_counter_reset_cmd, // Clear the crossing counter.
    input  wire logic              event_reset_cmd,         // Clear the data path.
    input  wire logic [LAT_W-1:0]  trig_latency,            // Programmed hit latency.
    input  wire logic              rd_ready,                // Readout takes the row.
    output logic                   matrix_trig_q,           // Trigger pulse to matrix.
    output tbt_ptr_t               matrix_trig_id_q,        // Trigger identifier to matrix.
    output logic                   rd_valid_q,              // Row offered to readout.
    output tbt_tag_t               rd_tag_q,                // Tag of offered row.
    output tbt_bcid_t              rd_bcid_q,               // Crossing id of offered row.
    output logic                   table_full_q,            // All rows occupied.
    output logic                   table_empty_q,           // No row occupied.
    output logic                   trig_drop_q              // Trigger lost to a full table.
);

    // ----------------------------------------------------------------------
    // Types and storage
    // ----------------------------------------------------------------------
    // Readout sequencer states.
    typedef enum logic [1:0] {
        RD_IDLE,                                     // Waiting for an occupied row.
        RD_FETCH,                                    // Row read in flight.
        RD_OFFER                                     // Row shown to readout.
    } tbt_rd_state_t;

    tbt_mem_if mem_bus ();                           // Controller to storage link.

    // Synchroniser stages.
    logic          ext_s1_q, ext_s2_q, ext_s3_q;     // Trigger pin synchroniser and edge.
    logic          ext_s1_d, ext_s2_d, ext_s3_d;     // Their next values.
    logic          byp_s1_q, byp_s2_q;               // Bypass strap synchroniser.
    logic          byp_s1_d, byp_s2_d;               // Their next values.

    // Voted state.
    tbt_ptr_t      wptr_q [3];                       // Write pointer, three copies.
    tbt_ptr_t      rptr_q [3];                       // Read pointer, three copies.
    tbt_bcid_t     bcid_q [3];                       // Crossing counter, three copies.
    tbt_ptr_t      wptr, rptr, wptr_d, rptr_d;       // Voted values and next values.
    tbt_bcid_t     bcid, bcid_d;                     // Voted counter and next value.
    // Occupancy and readout.
    logic [ROWS-1:0] row_full_q, row_full_d;         // Occupied-row flags.
    logic          live_q, live_d;                   // Data path released by event reset.
    tbt_rd_state_t rd_state_q, rd_state_d;           // Readout sequencer.

    // Next output values.
    logic          matrix_trig_d;                    // Next matrix pulse.
    tbt_ptr_t      matrix_trig_id_d;                 // Next trigger identifier.
    logic          rd_valid_d;                       // Next offer flag.
    tbt_tag_t      rd_tag_d;                         // Next offered tag.
    tbt_bcid_t     rd_bcid_d;                        // Next offered crossing id.
    logic          table_full_d, table_empty_d;      // Next occupancy flags.
    logic          trig_drop_d;                      // Next drop pulse.

    // Selected trigger.
    logic          trig_sel;                         // Accepted trigger this crossing.
    tbt_tag_t      tag_sel;                          // Its tag.
    tbt_data_t     rd_word;                          // Corrected row payload.

    // ----------------------------------------------------------------------
    // Row storage
    // ----------------------------------------------------------------------
    tbt_row_mem #(
        .DEPTH   (ROWS)
    ) u_rows (
        .sys_clk (sys_clk),
        .rst     (rst),
        .port    (mem_bus.mem)
    );

    // ----------------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------------
    // The pins come from outside this clock, so each passes two flops; the
    // edge detector looks only at the second stage and a third flop.
    always_comb begin
        ext_s1_d = ext_trig_pin;
        ext_s2_d = ext_s1_q;
        ext_s3_d = ext_s2_q;

        byp_s1_d = bypass_pin;
        byp_s2_d = byp_s1_q;
    end

    // Register the synchroniser stages.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // Pins idle low, so no false edge.
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;

            byp_s1_q <= 1'b0;
            byp_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_s1_d;
            ext_s2_q <= ext_s2_d;
            ext_s3_q <= ext_s3_d;

            byp_s1_q <= byp_s1_d;
            byp_s2_q <= byp_s2_d;
        end
    end

    // ----------------------------------------------------------------------
    // Trigger source selection
    // ----------------------------------------------------------------------
    // Only one source is live at a time and each yields a single-cycle
    // pulse, so one trigger per crossing at most. There is no path from hit
    // activity: triggers come from the decoder or the pin only.
    always_comb begin
        if (byp_s2_q) begin
            // Bypass: pin edges.
            trig_sel = ext_s2_q & ~ext_s3_q;
            tag_sel  = {EXT_TAG_USER, EXT_TAG_POS};
        end else begin
            // Decoder pulses.
            trig_sel = cmd_trig_pulse;
            tag_sel  = {cmd_trig_tag, cmd_trig_pos};
        end
    end

    // ----------------------------------------------------------------------
    // Voted state
    // ----------------------------------------------------------------------
    // Each copy is rewritten from the vote every cycle, so a single upset
    // is scrubbed on the next edge instead of lingering.
    always_comb begin
        wptr    = tbt_vote_ptr(wptr_q[0], wptr_q[1], wptr_q[2]);
        rptr    = tbt_vote_ptr(rptr_q[0], rptr_q[1], rptr_q[2]);
        bcid    = tbt_vote_bcid(bcid_q[0], bcid_q[1], bcid_q[2]);
        // Corrected read word.
        rd_word = tbt_ham_dec(mem_bus.rd_data);
    end

    // ----------------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------------
    always_comb begin
        wptr_d           = wptr;
        rptr_d           = rptr;
        bcid_d           = bcid + BCID_STEP;
        row_full_d       = row_full_q;
        live_d           = live_q;
        rd_state_d       = rd_state_q;
        matrix_trig_d    = 1'b0;
        matrix_trig_id_d = matrix_trig_id_q;
        rd_valid_d       = rd_valid_q;
        rd_tag_d         = rd_tag_q;
        rd_bcid_d        = rd_bcid_q;
        trig_drop_d      = 1'b0;

        mem_bus.wr_en    = 1'b0;
        mem_bus.wr_addr  = wptr;
        mem_bus.wr_data  = tbt_ham_enc({tag_sel,
                                        tbt_bcid_t'(bcid - tbt_bcid_t'(trig_latency))});
        mem_bus.rd_en    = 1'b0;
        mem_bus.rd_addr  = rptr;

        // The counter reset command acts whatever the data path is doing.
        if (bunch_counter_reset_cmd) begin
            bcid_d = BCID_RST;
        end

        if (event_reset_cmd) begin
            // Event reset empties the table and releases the data path.
            wptr_d     = PTR_RST;
            rptr_d     = PTR_RST;
            row_full_d = '0;
            rd_state_d = RD_IDLE;
            rd_valid_d = 1'b0;
            live_d     = 1'b1;
        end else if (live_q) begin
            // Readout first, so a row freed here and a row filled below
            // never fight over the same flag.
            unique case (rd_state_q)
                RD_IDLE: begin
                    // Wait for a row.
                    if (row_full_q[rptr]) begin
                        mem_bus.rd_en = 1'b1;
                        rd_state_d    = RD_FETCH;
                    end
                end
                RD_FETCH: begin
                    // Latch the word.
                    rd_tag_d   = rd_word[DATA_TAG_LSB +: TAG_W];
                    rd_bcid_d  = rd_word[DATA_BCID_LSB +: BCID_W];
                    rd_valid_d = 1'b1;
                    rd_state_d = RD_OFFER;
                end
                RD_OFFER: begin
                    if (rd_ready) begin
                        // Taken: free it.
                        rd_valid_d       = 1'b0;
                        row_full_d[rptr] = 1'b0;
                        rptr_d           = rptr + PTR_STEP;
                        rd_state_d       = RD_IDLE;
                    end
                end
                default: begin
                    // Upset code: back to idle.
                    rd_state_d = RD_IDLE;
                end
            endcase

            // Trigger logging: the row flag is set after any clear above.
            if (trig_sel) begin
                if (row_full_q[wptr]) begin
                    // No free row.
                    trig_drop_d = 1'b1;
                end else begin
                    // Log and forward.
                    mem_bus.wr_en    = 1'b1;
                    row_full_d[wptr] = 1'b1;
                    wptr_d           = wptr + PTR_STEP;
                    matrix_trig_d    = 1'b1;
                    matrix_trig_id_d = wptr;
                end
            end
        end

        // Flags after this edge.
        table_full_d  = &row_full_d;
        table_empty_d = ~|row_full_d;
    end

    // ----------------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------------
    // Power-on reset only parks the data path: live_q stays low, so no
    // trigger is logged and nothing is read until an event reset arrives.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // Clear every copy.
            for (int i = 0; i < 3; i++) begin
                wptr_q[i] <= PTR_RST;
                rptr_q[i] <= PTR_RST;
                bcid_q[i] <= BCID_RST;
            end

            row_full_q       <= '0;
            live_q           <= 1'b0;
            rd_state_q       <= RD_IDLE;
            matrix_trig_q    <= 1'b0;
            matrix_trig_id_q <= PTR_RST;
            rd_valid_q       <= 1'b0;
            rd_tag_q         <= '0;
            rd_bcid_q        <= BCID_RST;
            table_full_q     <= 1'b0;
            table_empty_q    <= 1'b1;
            trig_drop_q      <= 1'b0;
        end else begin
            // Rewrite every copy.
            for (int i = 0; i < 3; i++) begin
                wptr_q[i] <= wptr_d;
                rptr_q[i] <= rptr_d;
                bcid_q[i] <= bcid_d;
            end

            row_full_q       <= row_full_d;
            live_q           <= live_d;
            rd_state_q       <= rd_state_d;
            matrix_trig_q    <= matrix_trig_d;
            matrix_trig_id_q <= matrix_trig_id_d;
            rd_valid_q       <= rd_valid_d;
            rd_tag_q         <= rd_tag_d;
            rd_bcid_q        <= rd_bcid_d;
            table_full_q     <= table_full_d;
            table_empty_q    <= table_empty_d;
            trig_drop_q      <= trig_drop_d;
        end
    end

endmodule // tbt_trigger_table

// file: tbt_trigger_table_sva.sv
module tbt_trigger_table_sva import tbt_pkg::*; (
    input wire logic                  sys_clk,                 // Crossing clock.
    input wire logic                  rst,                     // Async reset.
    input wire logic                  cmd_trig_pulse,          // Decoder trigger.
    input wire logic [TAG_USER_W-1:0] cmd_trig_tag,            // User code.
    input wire logic [TAG_POS_W-1:0]  cmd_trig_pos,            // Position.
    input wire logic                  ext_trig_pin,            // Pin trigger.
    input wire logic                  bypass_pin,              // Bypass strap.
    input wire logic                  bunch_counter_reset_cmd, // Counter clear.
    input wire logic                  event_reset_cmd,         // Data path clear.
    input wire logic [LAT_W-1:0]      trig_latency,            // Latency.
    input wire logic                  rd_ready,                // Readout accepts.
    input wire logic                  matrix_trig_q,           // Matrix pulse.
    input wire tbt_ptr_t              matrix_trig_id_q,        // Matrix id.
    input wire logic                  rd_valid_q,              // Row offered.
    input wire tbt_tag_t              rd_tag_q,                // Offered tag.
    input wire tbt_bcid_t             rd_bcid_q,               // Offered crossing.
    input wire logic                  table_full_q,            // Full flag.
    input wire logic                  table_empty_q,           // Empty flag.
    input wire logic                  trig_drop_q              // Drop pulse.
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // A row taken by readout, and the first trigger after a data path clear.
    sequence s_take; rd_valid_q && rd_ready; endsequence
    sequence s_first; event_reset_cmd ##1 (cmd_trig_pulse && !bypass_pin && !event_reset_cmd);
    endsequence
    a_no_self_trig: assert property (
        matrix_trig_q |-> $past(cmd_trig_pulse) || $past(ext_trig_pin, 2) ||
        $past(ext_trig_pin, 3) || $past(ext_trig_pin, 4)) else $error("matrix pulse with no cause");
    a_first_row: assert property (
        s_first |=> matrix_trig_q && matrix_trig_id_q == PTR_RST) else $error("first row not 0");
    a_id_step: assert property (
        matrix_trig_q && $past(matrix_trig_q) |-> matrix_trig_id_q == $past(matrix_trig_id_q)
        + PTR_STEP) else $error("trigger id did not step");
    a_drop_full: assert property (
        table_full_q && cmd_trig_pulse && !bypass_pin && !event_reset_cmd && !(rd_valid_q && rd_ready)
        |=> trig_drop_q && !matrix_trig_q) else $error("full table took a trigger");
    a_valid_hold: assert property (
        rd_valid_q && !rd_ready && !event_reset_cmd |=> rd_valid_q && $stable(rd_tag_q) &&
        $stable(rd_bcid_q)) else $error("offered row changed");
    a_take_gap: assert property (
        s_take |=> !rd_valid_q) else $error("taken row still offered");
    a_event_clear: assert property (
        event_reset_cmd |=> table_empty_q && !table_full_q && !rd_valid_q) else $error("not cleared");
    a_occupied_read: assert property (
        rd_valid_q |-> !table_empty_q) else $error("row offered from empty table");
    a_read_prompt: assert property (
        !table_empty_q && !rd_valid_q |-> ##[1:4] (rd_valid_q || table_empty_q))
        else $error("readout stalled");
endmodule // tbt_trigger_table_sva

bind tbt_trigger_table tbt_trigger_table_sva u_sva (.*);

// file: tbt_trigger_table_tb.sv
module tbt_trigger_table_tb import tbt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst = 1'b1, rd_ready, stall = 1'b1;
    logic cmd_trig_pulse = 1'b0, ext_trig_pin = 1'b0, bypass_pin = 1'b0;
    logic bunch_counter_reset_cmd = 1'b0, event_reset_cmd = 1'b0;
    logic [TAG_USER_W-1:0] cmd_trig_tag = 5'h00;
    logic [TAG_POS_W-1:0]  cmd_trig_pos = 2'h0;
    logic [LAT_W-1:0]      trig_latency = 9'h005;
    logic matrix_trig_q, rd_valid_q, table_full_q, table_empty_q, trig_drop_q;
    tbt_ptr_t  matrix_trig_id_q, qi[$];
    tbt_tag_t  rd_tag_q, et[$], qt[$];
    tbt_bcid_t rd_bcid_q, qb[$];
    int n_errors = 0, checked = 0, cyc = 0;

    tbt_trigger_table dut (.*);
    tbt_rd_model u_rd (.sys_clk(sys_clk), .stall(stall), .rd_ready(rd_ready));
    always #10 sys_clk = ~sys_clk;

    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Tag logged for a pin trigger.
    function automatic tbt_tag_t pin_tag();
        return {EXT_TAG_USER, EXT_TAG_POS};
    endfunction
    task automatic cyc_n(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Back-to-back decoder triggers with random tags, starting at this edge.
    task automatic trigs(input int n);
        logic [6:0] t;
        for (int i = 0; i < n; i++) begin
            t = 7'($urandom);
            cmd_trig_pulse <= 1'b1;
            {cmd_trig_tag, cmd_trig_pos} <= t;
            et.push_back(t);
            @(posedge sys_clk);
        end
        cmd_trig_pulse <= 1'b0;
    endtask
    // Data path clear, with a fresh latency for the rows that follow.
    task automatic ev();
        event_reset_cmd <= 1'b1;
        trig_latency <= 9'($urandom);
        @(posedge sys_clk);
        event_reset_cmd <= 1'b0;
    endtask
    // Let readout run until nothing is occupied; bounded so a hang shows.
    task automatic drain();
        int k;
        stall <= 1'b0;
        for (k = 0; k < 500 && (table_empty_q !== 1'b1 || rd_valid_q !== 1'b0); k++)
            @(posedge sys_clk);
        stall <= 1'b1;
        chk(k < 500, 1);
    endtask

    // Log every row taken and every matrix pulse; cut a hang short.
    always @(posedge sys_clk) begin
        if (rd_valid_q === 1'b1 && rd_ready === 1'b1) begin
            qt.push_back(rd_tag_q);
            qb.push_back(rd_bcid_q);
        end
        if (matrix_trig_q === 1'b1) qi.push_back(matrix_trig_id_q);
        cyc++;
        if (cyc > 3000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        void'($urandom(32'h17D01B12));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        cyc_n(2);
        trigs(2);
        cyc_n(5);
        chk(qi.size(), 0);
        chk(table_empty_q, 1);
        $display("test parked done");
        ev();
        et.delete();
        trigs(ROWS);
        cyc_n(3);
        chk(table_full_q, 1);
        chk(qi.size(), ROWS);
        for (int i = 0; i < ROWS; i++) chk(qi[i], i);
        cmd_trig_pulse <= 1'b1;
        @(posedge sys_clk);
        cmd_trig_pulse <= 1'b0;
        #1 chk(trig_drop_q, 1);
        @(posedge sys_clk);
        drain();
        chk(qt.size(), ROWS);
        for (int i = 0; i < ROWS; i++) chk(qt[i], et[i]);
        for (int i = 1; i < ROWS; i++) chk(16'(qb[i] - qb[i-1]), 1);
        $display("test fill drain done");
        qb.delete();
        for (int d = 4; d <= 9; d += 5) begin
            bunch_counter_reset_cmd <= 1'b1;
            @(posedge sys_clk);
            bunch_counter_reset_cmd <= 1'b0;
            cyc_n(d);
            trigs(1);
            cyc_n(3);
        end
        drain();
        chk(16'(qb[1] - qb[0]), 5);
        $display("test counter clear done");
        bypass_pin <= 1'b1;
        cyc_n(4);
        qi.delete();
        qt.delete();
        ext_trig_pin <= 1'b1;
        cyc_n(2);
        ext_trig_pin <= 1'b0;
        cyc_n(6);
        chk(qi.size(), 1);
        drain();
        chk(qt[0], pin_tag());
        $display("test bypass done");
        final_report();
    end
endmodule // tbt_trigger_table_tb
